// ==== logic/cefc_top.v ====
`timescale 1ns/1ps
`default_nettype none
`include "cefc_regs.vh"
module cefc_top #(
	parameter NUM_CHAN = `CEFC_NUM_CHAN
) (
	input wire clk_i,
	input wire rst_i,
	input wire [7:0] station_addr_i,
	input wire rx_valid_i,
	input wire [7:0] rx_data_i,
	input wire rx_last_i,
	input wire tx_ready_i,
	output wire tx_valid_o,
	output wire [7:0] tx_data_o,
	output wire tx_last_o,
	output reg [NUM_CHAN-1:0] chan_enable_o,
	output reg filter_50hz_o
);
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_DECODE = 2'h1;
	localparam [1:0] ST_WAIT = 2'h2;
	localparam [7:0] MASK_RST = `CEFC_MASK_RST;

	wire req_done;
	wire [3:0] req_count;
	wire [31:0] req_bytes;
	wire tx_busy;

	reg [1:0] state;
	reg [3:0] cnt;
	reg [7:0] addr;
	reg [7:0] func;
	reg [7:0] sub;
	reg [7:0] arg;
	reg load;
	reg [2:0] load_len;
	reg [31:0] load_bytes;

	reg [1:0] next_state;
	reg next_load;
	reg [2:0] next_len;
	reg [31:0] next_bytes;
	reg [NUM_CHAN-1:0] next_mask;
	reg next_filter;
	reg is_read;
	reg is_write;
	reg bad;
	wire addr_ok;
	wire [7:0] mask_byte;
	wire [7:0] misc_byte;
	wire has_sub;
	wire func_ok;
	wire ours;
	wire decode;
	wire idle_take;
	wire reply_done;
	reg len_bad;
	reg range_bad;
	reg [7:0] data_byte;
	reg take_mask;
	reg take_filter;

	cefc_rx_capture #(
		.KEEP(4)
	) u_rx (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.byte_valid_i(rx_valid_i),
		.byte_data_i(rx_data_i),
		.byte_last_i(rx_last_i),
		.req_done_o(req_done),
		.req_count_o(req_count),
		.req_bytes_o(req_bytes)
	);

	cefc_tx_shift u_tx (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.load_i(load),
		.load_len_i(load_len),
		.load_bytes_i(load_bytes),
		.busy_o(tx_busy),
		.tx_ready_i(tx_ready_i),
		.tx_valid_o(tx_valid_o),
		.tx_data_o(tx_data_o),
		.tx_last_o(tx_last_o)
	);

	// Station address must be legal and match the request
	assign addr_ok = (station_addr_i >= `CEFC_ADDR_MIN) && (station_addr_i <= `CEFC_ADDR_MAX) &&
		(addr == station_addr_i);

	// Mask read back zero-extended, bit n is channel n
	assign mask_byte = {{(8-NUM_CHAN){1'b0}}, chan_enable_o};

	// Settings read back: filter bit on top, the rest zero
	assign misc_byte = {filter_50hz_o, 7'h00} & ~`CEFC_MISC_RSV;

	// Frames too short to carry a sub-function are not decoded, stale bytes stay unused
	assign has_sub = (cnt >= `CEFC_LEN_READ);
	assign func_ok = (func == `CEFC_FUNC);
	assign decode = (state == ST_DECODE);
	assign idle_take = (state == ST_IDLE) && req_done;
	assign reply_done = !load && !tx_busy;
	assign ours = addr_ok && func_ok && has_sub && (is_read || is_write);

	always @* begin
		is_read = 1'b0;
		is_write = 1'b0;
		case (sub)
			`CEFC_SUB_RD_MASK: begin
				is_read = 1'b1;
			end
			`CEFC_SUB_RD_MISC: begin
				is_read = 1'b1;
			end
			`CEFC_SUB_WR_MASK: begin
				is_write = 1'b1;
			end
			`CEFC_SUB_WR_MISC: begin
				is_write = 1'b1;
			end
			default: begin
				is_read = 1'b0;
				is_write = 1'b0;
			end
		endcase
	end

	// Length check applies to all four sub-functions
	always @* begin
		len_bad = 1'b0;
		if (is_read && cnt != `CEFC_LEN_READ) begin
			len_bad = 1'b1;
		end
		if (is_write && cnt != `CEFC_LEN_WRITE) begin
			len_bad = 1'b1;
		end
	end

	always @* begin
		range_bad = 1'b0;
		case (sub)
			`CEFC_SUB_WR_MASK: begin
				if ((arg >> NUM_CHAN) != 8'h00) begin
					range_bad = 1'b1;
				end
			end
			`CEFC_SUB_WR_MISC: begin
				if ((arg & `CEFC_MISC_RSV) != 8'h00) begin
					range_bad = 1'b1;
				end
			end
			default: begin
				range_bad = 1'b0;
			end
		endcase
		bad = len_bad || range_bad;
	end

	// Fourth reply byte: read data or the write result
	always @* begin
		data_byte = `CEFC_RESULT_OK;
		case (sub)
			`CEFC_SUB_RD_MASK: begin
				data_byte = mask_byte;
			end
			`CEFC_SUB_RD_MISC: begin
				data_byte = misc_byte;
			end
			default: begin
				data_byte = `CEFC_RESULT_OK;
			end
		endcase
	end

	// Stored settings change only on a clean write
	always @* begin
		take_mask = 1'b0;
		take_filter = 1'b0;
		if (decode && ours && !bad) begin
			case (sub)
				`CEFC_SUB_WR_MASK: begin
					take_mask = 1'b1;
				end
				`CEFC_SUB_WR_MISC: begin
					take_filter = 1'b1;
				end
				default: begin
					take_mask = 1'b0;
					take_filter = 1'b0;
				end
			endcase
		end
	end

	always @* begin
		next_mask = chan_enable_o;
		next_filter = filter_50hz_o;
		if (take_mask) begin
			next_mask = arg[NUM_CHAN-1:0];
		end
		if (take_filter) begin
			next_filter = arg[`CEFC_FILTER_BIT];
		end
	end

	// Decode lasts one cycle, then the reply drains before the next frame is taken
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (req_done) begin
					next_state = ST_DECODE;
				end
			end
			ST_DECODE: begin
				if (ours) begin
					next_state = ST_WAIT;
				end else begin
					next_state = ST_IDLE;
				end
			end
			ST_WAIT: begin
				if (reply_done) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// Reply image, byte 0 goes out first
	always @* begin
		next_load = 1'b0;
		next_len = load_len;
		next_bytes = load_bytes;
		if (decode && ours) begin
			next_load = 1'b1;
			if (bad) begin
				// Exception reply, stored settings untouched
				next_len = `CEFC_REPLY_LEN_EXC;
				next_bytes = {8'h00, `CEFC_EXC_CODE, `CEFC_EXC_FUNC, addr};
			end else begin
				next_len = `CEFC_REPLY_LEN_NORMAL;
				next_bytes = {data_byte, sub, func, addr};
			end
		end
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Latch the request so a following frame cannot disturb decode
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt <= 4'h0;
			addr <= 8'h00;
			func <= 8'h00;
			sub <= 8'h00;
			arg <= 8'h00;
		end else if (idle_take) begin
			cnt <= req_count;
			addr <= req_bytes[7:0];
			func <= req_bytes[15:8];
			sub <= req_bytes[23:16];
			arg <= req_bytes[31:24];
		end
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			load <= 1'b0;
			load_len <= 3'h0;
			load_bytes <= 32'h0;
		end else begin
			load <= next_load;
			load_len <= next_len;
			load_bytes <= next_bytes;
		end
	end

	// Settings registers drive the channel and filter outputs directly
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			chan_enable_o <= MASK_RST[NUM_CHAN-1:0];
			filter_50hz_o <= `CEFC_FILTER_RST;
		end else begin
			chan_enable_o <= next_mask;
			filter_50hz_o <= next_filter;
		end
	end
endmodule // cefc_top
`default_nettype wire

// ==== logic/cefc_regs.vh ====
// Contract
// - A read-mask request (function 0x46, sub-function 0x25) is answered with address, function, sub-function and the current channel enable mask.
// - The enable mask covers 0x00 to 0x3F, bit n holding the state of analog channel n for channels 0 to 5.
// - A mask bit of one means the channel is active and a mask bit of zero means it is switched off.
// - A write-mask request (sub-function 0x26) carries a new mask byte, which the block applies to the channel enables.
// - A supplied mask above 0x3F is refused with function 0xC6 and exception code 03, and the mask stays as it was.
// - A read-settings request (sub-function 0x29) is answered with address, function, sub-function and one settings byte.
// - Settings bit 7 selects the rejection filter, zero for 60 Hz and one for 50 Hz.
// - In the returned settings byte, bits 6 to 0 always read as zero.
// - A write-settings request (sub-function 0x2A) carries one settings byte whose filter bit the block stores.
// - The master writes zeros in settings bits 6 to 0, and a nonzero value there is refused with 0xC6 and code 03.
// - A request of any of the four sub-functions with the wrong byte count is refused with 0xC6 and code 03.
`ifndef CEFC_REGS_VH
`define CEFC_REGS_VH

`define CEFC_FUNC 8'h46
`define CEFC_EXC_FUNC 8'hC6
`define CEFC_EXC_CODE 8'h03
`define CEFC_SUB_RD_MASK 8'h25
`define CEFC_SUB_WR_MASK 8'h26
`define CEFC_SUB_RD_MISC 8'h29
`define CEFC_SUB_WR_MISC 8'h2A
`define CEFC_NUM_CHAN 6
`define CEFC_FILTER_BIT 7
`define CEFC_MISC_RSV 8'h7F
`define CEFC_LEN_READ 4'h3
`define CEFC_LEN_WRITE 4'h4
`define CEFC_ADDR_MIN 8'h01
`define CEFC_ADDR_MAX 8'hF7
`define CEFC_MASK_RST 8'h3F
`define CEFC_FILTER_RST 1'b0
`define CEFC_RESULT_OK 8'h00
`define CEFC_REPLY_LEN_NORMAL 3'h4
`define CEFC_REPLY_LEN_EXC 3'h3

`endif

// ==== logic/cefc_rx_capture.v ====
`timescale 1ns/1ps
`default_nettype none
module cefc_rx_capture #(
	parameter KEEP = 4
) (
	input wire clk_i,
	input wire rst_i,
	input wire byte_valid_i,
	input wire [7:0] byte_data_i,
	input wire byte_last_i,
	output reg req_done_o,
	output reg [3:0] req_count_o,
	output reg [8*KEEP-1:0] req_bytes_o
);
	localparam [3:0] KEEP_N = KEEP[3:0];
	reg [3:0] count;
	wire [3:0] next_count;

	// Byte count saturates so long frames still read as wrong length
	assign next_count = (count == 4'hF) ? count : count + 4'h1;

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			count <= 4'h0;
			req_done_o <= 1'b0;
			req_count_o <= 4'h0;
			req_bytes_o <= {(8*KEEP){1'b0}};
		end else begin
			req_done_o <= 1'b0;
			if (byte_valid_i) begin
				if (count < KEEP_N) begin
					req_bytes_o[count*8 +: 8] <= byte_data_i;
				end
				if (byte_last_i) begin
					req_done_o <= 1'b1;
					req_count_o <= next_count;
					count <= 4'h0;
				end else begin
					count <= next_count;
				end
			end
		end
	end
endmodule // cefc_rx_capture
`default_nettype wire

// ==== logic/cefc_tx_shift.v ====
`timescale 1ns/1ps
`default_nettype none
module cefc_tx_shift (
	input wire clk_i,
	input wire rst_i,
	input wire load_i,
	input wire [2:0] load_len_i,
	input wire [31:0] load_bytes_i,
	output wire busy_o,
	input wire tx_ready_i,
	output reg tx_valid_o,
	output reg [7:0] tx_data_o,
	output reg tx_last_o
);
	reg [31:0] bytes;
	reg [1:0] idx;
	reg [2:0] len;
	wire [1:0] next_idx;
	wire [2:0] after_next;

	assign busy_o = tx_valid_o;
	assign next_idx = idx + 2'h1;
	assign after_next = {1'b0, idx} + 3'h2;

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bytes <= 32'h0;
			idx <= 2'h0;
			len <= 3'h0;
			tx_valid_o <= 1'b0;
			tx_data_o <= 8'h00;
			tx_last_o <= 1'b0;
		end else if (!tx_valid_o) begin
			if (load_i) begin
				bytes <= load_bytes_i;
				len <= load_len_i;
				idx <= 2'h0;
				tx_valid_o <= 1'b1;
				tx_data_o <= load_bytes_i[7:0];
				tx_last_o <= (load_len_i == 3'h1);
			end
		end else if (tx_ready_i) begin
			if (tx_last_o) begin
				tx_valid_o <= 1'b0;
				tx_last_o <= 1'b0;
			end else begin
				idx <= next_idx;
				tx_data_o <= bytes[next_idx*8 +: 8];
				tx_last_o <= (after_next == len);
			end
		end
	end
endmodule // cefc_tx_shift
`default_nettype wire

// ==== test/cefc_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module cefc_props #(parameter NUM_CHAN = 6) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] station_addr_i,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	input wire logic rx_last_i,
	input wire logic tx_ready_i,
	input wire logic tx_valid_o,
	input wire logic [7:0] tx_data_o,
	input wire logic tx_last_o,
	input wire logic [NUM_CHAN-1:0] chan_enable_o,
	input wire logic filter_50hz_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [23:0] sh, rp;
	logic [3:0] cnt, idx;
	wire end_rx = rx_valid_i && rx_last_i;
	wire w4 = end_rx && cnt == 4'h3 && sh[23:8] == {station_addr_i, 8'h46};
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			{sh, rp, cnt, idx} <= 56'h0;
		end else begin
			if (rx_valid_i) begin
				sh <= {sh[15:0], rx_data_i};
				cnt <= rx_last_i ? 4'h0 : cnt + 4'h1;
			end
			if (tx_valid_o && tx_ready_i) begin
				rp <= {rp[15:0], tx_data_o};
				idx <= tx_last_o ? 4'h0 : idx + 4'h1;
			end
		end
	end
	sequence s_mask_kept; $stable(chan_enable_o) [*8]; endsequence
	sequence s_silent; !tx_valid_o [*8]; endsequence
	property p_wmask; w4 && sh[7:0] == 8'h26 && rx_data_i < 8'h40 |=> ##[0:3] chan_enable_o == sh[NUM_CHAN-1:0]; endproperty
	property p_bmask; w4 && sh[7:0] == 8'h26 && rx_data_i > 8'h3F |=> s_mask_kept; endproperty
	property p_wfilt; w4 && sh[7:0] == 8'h2A && rx_data_i[6:0] == 7'h00 |=> ##[0:3] filter_50hz_o == sh[7]; endproperty
	property p_bfilt; w4 && sh[7:0] == 8'h2A && rx_data_i[6:0] != 7'h00 |=> $stable(filter_50hz_o) [*8]; endproperty
	property p_addr; $rose(tx_valid_o) |-> tx_data_o == station_addr_i; endproperty
	property p_exc; tx_valid_o && idx == 4'h2 && rp[7:0] == 8'hC6 |-> tx_data_o == 8'h03 && tx_last_o; endproperty
	property p_data; tx_valid_o && idx == 4'h3 |-> tx_last_o && tx_data_o == (rp[7:0] == 8'h25 ? 8'(chan_enable_o)
		: rp[7:0] == 8'h29 ? {filter_50hz_o, 7'h00} : 8'h00); endproperty
	property p_quiet; end_rx && cnt == 4'h2 && sh[15:8] != station_addr_i && !tx_valid_o |=> s_silent; endproperty
	a_wmask: assert property (p_wmask) else $error("mask not written");
	a_bmask: assert property (p_bmask) else $error("bad mask applied");
	a_wfilt: assert property (p_wfilt) else $error("filter not written");
	a_bfilt: assert property (p_bfilt) else $error("bad settings applied");
	a_addr: assert property (p_addr) else $error("reply address wrong");
	a_exc: assert property (p_exc) else $error("exception reply wrong");
	a_data: assert property (p_data) else $error("reply data wrong");
	property p_ffunc; end_rx && cnt == 4'h2 && sh[7:0] != 8'h46 && !tx_valid_o |=> s_silent; endproperty
	property p_short; end_rx && cnt < 4'h2 && !tx_valid_o |=> s_silent; endproperty
	a_quiet: assert property (p_quiet) else $error("foreign frame answered");
	a_ffunc: assert property (p_ffunc) else $error("foreign function answered");
	a_short: assert property (p_short) else $error("short frame answered");
endmodule // cefc_props
bind cefc_top cefc_props #(.NUM_CHAN(NUM_CHAN)) cefc_props_inst (.clk_i, .rst_i, .station_addr_i, .rx_valid_i,
	.rx_data_i, .rx_last_i, .tx_ready_i, .tx_valid_o, .tx_data_o, .tx_last_o, .chan_enable_o, .filter_50hz_o);
`default_nettype wire

// ==== test/cefc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cefc_host_model (
	input wire logic clk_i,
	output logic v_o,
	output logic [7:0] d_o,
	output logic l_o,
	output logic rdy_o,
	input wire logic tv_i,
	input wire logic [7:0] td_i,
	input wire logic tl_i
);
	initial {v_o, d_o, l_o, rdy_o} = 11'h0;
	task send(input logic [31:0] q, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			@(negedge clk_i);
			v_o = 1'b1;
			d_o = q[8*i+:8];
			l_o = i == 0;
		end
		@(negedge clk_i);
		{v_o, l_o} = 2'h0;
		d_o = ~d_o;
	endtask
	task recv(output logic [31:0] r, output int n, input int slow);
		bit done;
		{r, n, done} = 65'h0;
		for (int t = 0; t < 40; t++) begin
			@(negedge clk_i);
			rdy_o = !done && t % (slow + 1) == slow;
			if (rdy_o && tv_i) begin
				r = {r[23:0], td_i};
				n++;
				done = tl_i;
			end
		end
	endtask
endmodule // cefc_host_model
`default_nettype wire

// ==== test/channel_enable_filter_cmd_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; $display("Error %s exp %h got %h", n, e, g); end end
module channel_enable_filter_cmd_bench;
	logic clk_i = 1'b0, rst_i = 1'b1;
	logic [7:0] station_addr_i = 8'h01;
	wire logic rx_valid_i, rx_last_i, tx_ready_i, tx_valid_o, tx_last_o, filter_50hz_o;
	wire logic [7:0] rx_data_i, tx_data_o;
	wire logic [5:0] chan_enable_o;
	int err_total = 0, comparisons = 0;
	always #2 clk_i = ~clk_i;
	cefc_top cefc_top_inst (.clk_i, .rst_i, .station_addr_i, .rx_valid_i, .rx_data_i, .rx_last_i, .tx_ready_i,
		.tx_valid_o, .tx_data_o, .tx_last_o, .chan_enable_o, .filter_50hz_o);
	cefc_host_model cefc_host_model_inst (.clk_i(clk_i), .v_o(rx_valid_i), .d_o(rx_data_i), .l_o(rx_last_i),
		.rdy_o(tx_ready_i), .tv_i(tx_valid_o), .td_i(tx_data_o), .tl_i(tx_last_o));
	task run(input logic [31:0] q, input int n, input logic [31:0] e, input int m);
		logic [31:0] r;
		int k;
		cefc_host_model_inst.send(q, n);
		cefc_host_model_inst.recv(r, k, comparisons % 3);
		`CHK("reply count", m, k)
		`CHK("reply", e, r)
	endtask
	task t_mask;
		`CHK("reset mask", 6'h3F, chan_enable_o)
		run(32'h00014625, 3, 32'h0146253F, 4);
		run(32'h01462615, 4, 32'h01462600, 4);
		`CHK("mask", 6'h15, chan_enable_o)
		run(32'h00014625, 3, 32'h01462515, 4);
		run(32'h01462640, 4, 32'h0001C603, 3);
		`CHK("mask kept", 6'h15, chan_enable_o)
	endtask
	task t_misc;
		`CHK("reset filter", 1'b0, filter_50hz_o)
		run(32'h01462A80, 4, 32'h01462A00, 4);
		`CHK("filter", 1'b1, filter_50hz_o)
		run(32'h00014629, 3, 32'h01462980, 4);
		run(32'h01462A81, 4, 32'h0001C603, 3);
		run(32'h01462A00, 4, 32'h01462A00, 4);
		run(32'h00014629, 3, 32'h01462900, 4);
	endtask
	task t_len;
		logic [7:0] s [4];
		s = '{8'h25, 8'h26, 8'h29, 8'h2A};
		for (int i = 0; i < 4; i++)
			run(i % 2 ? {16'h0146, s[i]} : {16'h0146, s[i], 8'h00}, i % 2 ? 3 : 4, 32'h0001C603, 3);
	endtask
	task t_addr;
		@(negedge clk_i) station_addr_i = 8'hF7;
		run(32'h00F74625, 3, 32'hF7462515, 4);
		run(32'h0000F746, 2, 32'h0, 0);
		run(32'h00F70325, 3, 32'h0, 0);
		run(32'h00F74627, 3, 32'h0, 0);
		run(32'h00014625, 3, 32'h0, 0);
		@(negedge clk_i) station_addr_i = 8'h00;
		run(32'h00004625, 3, 32'h0, 0);
	endtask
	task print_verdict;
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#20000;
		err_total++;
		print_verdict;
	end
	initial begin
		repeat (8) @(negedge clk_i);
		rst_i = 1'b0;
		t_mask;
		t_misc;
		t_len;
		t_addr;
		print_verdict;
	end
endmodule // channel_enable_filter_cmd_bench
`default_nettype wire
